// File: dhc_pkg.sv
// Constants and types for the page-mode dynamic memory host controller
// Summary of operation
// - 18-bit cell address goes out as two 9-bit halves, each set before its strobe.
// - Write select high means read, low means write.
// - Page bursts read, write or read-modify-write inside one row only.
// - Burst opens row then column; column strobe toggles with new columns.
// - Raising row strobe ends the page burst.
// - Controller strobes all 512 rows within every 8 ms.
package dhc_pkg;
   localparam int ROW_W         = 9;
   localparam int ADDR_W        = 18;
   localparam int DATA_W        = 4;
   localparam int ROWS          = 512;
   localparam int CLK_MHZ       = 50;
   localparam int CLK_NS        = 20;
   localparam int SYNC_STAGES   = 2;
   localparam int TMR_W         = 8;
   localparam int PAGE_GUARD    = 16;
   // Device timing, least values unless noted
   localparam int T_RP_NS       = 50;
   localparam int T_RCD_NS      = 20;
   localparam int T_CAS_NS      = 20;
   localparam int T_CP_NS       = 10;
   localparam int T_RAS_NS      = 70;
   localparam int T_RAC_NS      = 70;
   localparam int T_OE_NS       = 20;
   localparam int T_WP_NS       = 35;
   localparam int T_CSR_NS      = 15;
   localparam int T_RAS_MAX_NS  = 100000;
   localparam int T_REF_MS      = 8;
   localparam int C_RP          = (T_RP_NS + CLK_NS - 1) / CLK_NS;
   localparam int C_RCD         = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
   localparam int C_CAS         = (T_CAS_NS + CLK_NS - 1) / CLK_NS;
   localparam int C_CP          = (T_CP_NS + CLK_NS - 1) / CLK_NS;
   localparam int C_RAS         = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
   localparam int C_RAC         = (T_RAC_NS + CLK_NS - 1) / CLK_NS;
   localparam int C_OE          = (T_OE_NS + CLK_NS - 1) / CLK_NS;
   localparam int C_WP          = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int C_CSR         = (T_CSR_NS + CLK_NS - 1) / CLK_NS;
   localparam int C_RD          = C_RAC + SYNC_STAGES;
   localparam int C_WR          = (C_WP > C_CAS) ? C_WP : C_CAS;
   localparam int C_RAS_MAX     = T_RAS_MAX_NS / CLK_NS;
   // Milliseconds to microseconds, then cycles per microsecond
   localparam int C_REF_PERIOD  = T_REF_MS * 1000 * CLK_MHZ;
   typedef enum logic [1:0] {DHC_OP_READ, DHC_OP_WRITE, DHC_OP_RMW} dhc_op_t;
endpackage

// File: dhc_sync_if.sv
// Carrier between the pin sampler and the controller
`timescale 1ns/1ps
interface dhc_sync_if #(parameter int W = 4);
   logic [W-1:0] async_in;
   logic [W-1:0] sync_out;
   modport src (output async_in, input sync_out);
   modport snk (input async_in, output sync_out);
endinterface

// File: dhc_sync.sv
// Two-stage synchroniser for the data pin inputs
`timescale 1ns/1ps
module dhc_sync #(parameter int W = 4)
(
   input  wire logic mclk,
   input  wire logic sys_rst,
   dhc_sync_if.snk   sif
);
   import dhc_pkg::*;
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } dhc_sync_st_t;
   dhc_sync_st_t q;
   dhc_sync_st_t d;

   always_comb
   begin
      d      = q;
      d.meta = sif.async_in;
      d.stab = q.meta;
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign sif.sync_out = q.stab;
endmodule

// File: dhc_ctrl.sv
// Host controller driving an asynchronous page-mode dynamic memory
`timescale 1ns/1ps
module dhc_ctrl #(
   parameter int REF_PERIOD_CYC = dhc_pkg::C_REF_PERIOD,
   parameter int RAS_MAX_CYC    = dhc_pkg::C_RAS_MAX
)
(
   input  wire logic                         mclk,
   input  wire logic                         sys_rst,
   input  wire logic                         req_valid,
   output logic                              req_ready,
   input  wire dhc_pkg::dhc_op_t             req_op,
   input  wire logic [dhc_pkg::ADDR_W-1:0]   req_addr,
   input  wire logic [dhc_pkg::DATA_W-1:0]   req_wdata,
   output logic                              rsp_valid,
   output logic [dhc_pkg::DATA_W-1:0]        rsp_rdata,
   output logic                              row_strobe_n,
   output logic                              column_strobe_n,
   output logic                              write_select_n,
   output logic                              output_gate_n,
   output logic [dhc_pkg::ROW_W-1:0]         mux_address_lines,
   output logic [dhc_pkg::DATA_W-1:0]        data_pins_o,
   output logic                              data_pins_oe,
   input  wire logic [dhc_pkg::DATA_W-1:0]   data_pins_i
);
   import dhc_pkg::*;
   localparam int REF_INT = REF_PERIOD_CYC / ROWS;
   localparam int RCNT_W  = $clog2(REF_PERIOD_CYC + 1);
   localparam int ACNT_W  = $clog2(RAS_MAX_CYC + 1);

   typedef enum {ST_IDLE, ST_RAS, ST_RCD, ST_CAS, ST_CWAIT, ST_TURN, ST_LATEWE,
                 ST_CP, ST_CLOSE, ST_PRE, ST_CBR_RAS, ST_CBR_HOLD} dhc_st_t;
   typedef struct packed {
      dhc_st_t                st;
      logic [TMR_W-1:0]       tmr;
      logic [ACNT_W-1:0]      ras_cnt;
      logic [RCNT_W-1:0]      ref_cnt;
      logic                   ref_pend;
      dhc_op_t                op;
      logic [ROW_W-1:0]       row;
      logic [ROW_W-1:0]       col;
      logic [DATA_W-1:0]      wdata;
      logic [DATA_W-1:0]      rdata;
      logic                   rsp;
      logic                   ras;
      logic                   cas;
      logic                   we;
      logic                   oe;
      logic [ROW_W-1:0]       addr;
      logic [DATA_W-1:0]      dq;
      logic                   dq_en;
   } dhc_ctrl_st_t;

   dhc_ctrl_st_t q;
   dhc_ctrl_st_t d;
   logic         page_hit;
   logic         accept;
   dhc_sync_if #(.W(DATA_W)) sif ();

   assign sif.async_in = data_pins_i;

   dhc_sync #(.W(DATA_W)) u_sync (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .sif     (sif)
   );

   // Same row, no refresh waiting, row still well inside its longest low time
   assign page_hit = (q.st == ST_CP) && (q.tmr == '0) && !q.ref_pend
                     && (req_addr[ADDR_W-1:ROW_W] == q.row)
                     && (q.ras_cnt < ACNT_W'(RAS_MAX_CYC - PAGE_GUARD));
   assign req_ready = ((q.st == ST_IDLE) && !q.ref_pend) || page_hit;
   assign accept    = req_valid && req_ready;

   always_comb
   begin
      d     = q;
      d.rsp = 1'b0;
      if (q.tmr != '0)
      begin
         d.tmr = q.tmr - 1'b1;
      end
      // Row-low time, saturating
      if (!q.ras)
      begin
         d.ras_cnt = '0;
      end
      else if (q.ras_cnt != ACNT_W'(RAS_MAX_CYC))
      begin
         d.ras_cnt = q.ras_cnt + 1'b1;
      end
      // Distributed refresh tick
      if (q.ref_cnt == '0)
      begin
         d.ref_cnt  = RCNT_W'(REF_INT - 1);
         d.ref_pend = 1'b1;
      end
      else
      begin
         d.ref_cnt = q.ref_cnt - 1'b1;
      end
      if (accept)
      begin
         d.op    = req_op;
         d.row   = req_addr[ADDR_W-1:ROW_W];
         d.col   = req_addr[ROW_W-1:0];
         d.wdata = req_wdata;
      end
      unique case (q.st)
         ST_IDLE:
         begin
            if (q.ref_pend)
            begin
               d.cas = 1'b1;
               d.tmr = TMR_W'(C_CSR);
               d.st  = ST_CBR_RAS;
            end
            else if (accept)
            begin
               d.addr = req_addr[ADDR_W-1:ROW_W];
               d.st   = ST_RAS;
            end
         end
         ST_RAS:
         begin
            d.ras = 1'b1;
            d.tmr = TMR_W'(C_RCD);
            d.st  = ST_RCD;
         end
         ST_RCD:
         begin
            if (q.tmr == '0)
            begin
               d.addr  = q.col;
               d.we    = (q.op == DHC_OP_WRITE);
               d.oe    = (q.op != DHC_OP_WRITE);
               d.dq    = q.wdata;
               d.dq_en = (q.op == DHC_OP_WRITE);
               d.st    = ST_CAS;
            end
         end
         ST_CAS:
         begin
            d.cas = 1'b1;
            d.tmr = (q.op == DHC_OP_WRITE) ? TMR_W'(C_WR) : TMR_W'(C_RD);
            d.st  = ST_CWAIT;
         end
         ST_CWAIT:
         begin
            if (q.tmr == '0)
            begin
               if (q.op != DHC_OP_WRITE)
               begin
                  d.rdata = sif.sync_out;
               end
               if (q.op == DHC_OP_RMW)
               begin
                  // Release the gate before taking the pins back
                  d.oe  = 1'b0;
                  d.tmr = TMR_W'(C_OE);
                  d.st  = ST_TURN;
               end
               else
               begin
                  d.cas   = 1'b0;
                  d.we    = 1'b0;
                  d.oe    = 1'b0;
                  d.dq_en = 1'b0;
                  d.rsp   = 1'b1;
                  d.tmr   = TMR_W'(C_CP);
                  d.st    = ST_CP;
               end
            end
         end
         ST_TURN:
         begin
            if (q.tmr == '0)
            begin
               d.dq_en = 1'b1;
               d.st    = ST_LATEWE;
            end
         end
         ST_LATEWE:
         begin
            d.we  = 1'b1;
            d.op  = DHC_OP_WRITE;
            d.tmr = TMR_W'(C_WP);
            d.st  = ST_CWAIT;
         end
         ST_CP:
         begin
            if (q.tmr == '0)
            begin
               if (accept)
               begin
                  d.st = ST_RCD;
               end
               else
               begin
                  d.st = ST_CLOSE;
               end
            end
         end
         ST_CLOSE:
         begin
            if (q.ras_cnt >= ACNT_W'(C_RAS))
            begin
               d.ras = 1'b0;
               d.tmr = TMR_W'(C_RP);
               d.st  = ST_PRE;
            end
         end
         ST_PRE:
         begin
            if (q.tmr == '0)
            begin
               d.st = ST_IDLE;
            end
         end
         ST_CBR_RAS:
         begin
            if (q.tmr == '0)
            begin
               d.ras = 1'b1;
               d.tmr = TMR_W'(C_RAS);
               d.st  = ST_CBR_HOLD;
            end
         end
         ST_CBR_HOLD:
         begin
            if (q.tmr == '0)
            begin
               d.ras = 1'b0;
               d.cas = 1'b0;
               d.tmr = TMR_W'(C_RP);
               d.st  = ST_PRE;
               // A tick landing now keeps its request
               d.ref_pend = (q.ref_cnt == '0);
            end
         end
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign row_strobe_n      = ~q.ras;
   assign column_strobe_n   = ~q.cas;
   assign write_select_n    = ~q.we;
   assign output_gate_n     = ~q.oe;
   assign mux_address_lines = q.addr;
   assign data_pins_o       = q.dq;
   assign data_pins_oe      = q.dq_en;
   assign rsp_valid         = q.rsp;
   assign rsp_rdata         = q.rdata;

   // Cycles since the last refresh strobe
   logic [RCNT_W:0] since_ref_q;
   always_ff @(posedge mclk)
   begin
      if (sys_rst || (q.st == ST_CBR_HOLD && q.tmr == '0))
      begin
         since_ref_q <= '0;
      end
      else if (since_ref_q != '1)
      begin
         since_ref_q <= since_ref_q + 1'b1;
      end
   end

   sequence s_col_fall;
      $fell(column_strobe_n) && !row_strobe_n;
   endsequence
   sequence s_row_open;
      $fell(row_strobe_n) && column_strobe_n;
   endsequence

   a_addr_setup_time:
   assert property (@(posedge mclk) disable iff (sys_rst)
      ($fell(row_strobe_n) || $fell(column_strobe_n)) |-> $stable(mux_address_lines))
      else $error("address changed at strobe fall");
   a_write_data_drive:
   assert property (@(posedge mclk) disable iff (sys_rst)
      s_col_fall ##0 !write_select_n |-> data_pins_oe && output_gate_n)
      else $error("early write without driven data");
   a_read_no_drive:
   assert property (@(posedge mclk) disable iff (sys_rst)
      s_col_fall ##0 write_select_n |-> !data_pins_oe ##1 (write_select_n && !output_gate_n))
      else $error("read cycle with host driving pins");
   a_page_same_row:
   assert property (@(posedge mclk) disable iff (sys_rst)
      (!row_strobe_n && $past(!row_strobe_n)) |-> $stable(q.row))
      else $error("row changed inside page");
   a_row_then_column:
   assert property (@(posedge mclk) disable iff (sys_rst)
      s_row_open |-> (column_strobe_n && !row_strobe_n) [*2])
      else $error("column strobe too soon after row strobe");
   a_burst_end_rise:
   assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(row_strobe_n) |-> column_strobe_n ##1 row_strobe_n [*3])
      else $error("row strobe rose with column low or short precharge");
   a_refresh_bound:
   assert property (@(posedge mclk) disable iff (sys_rst)
      since_ref_q <= (RCNT_W+1)'(2 * REF_INT + RAS_MAX_CYC + 64))
      else $error("refresh strobe overdue");
endmodule

// File: dhc_dram_model.sv
// Behavioural page-mode dynamic memory facing the host controller
`timescale 1ns/1ps
module dhc_dram_model
(
   input  wire logic                       row_strobe_n,
   input  wire logic                       column_strobe_n,
   input  wire logic                       write_select_n,
   input  wire logic                       output_gate_n,
   input  wire logic [dhc_pkg::ROW_W-1:0]  mux_address_lines,
   input  wire logic [dhc_pkg::DATA_W-1:0] dq,
   output logic [dhc_pkg::DATA_W-1:0]      dq_q,
   output logic                            dq_oe
);
   import dhc_pkg::*;
   logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];
   logic [ROW_W-1:0]  row_q, col_q;
   logic [ROW_W-1:0]  refr_cnt = '0;
   logic              row_open = 1'b0;
   logic              rd_act = 1'b0;
   logic              acc_ok = 1'b0;
   int                acc_ns = 30;
   int                cbr_count = 0;
   int                page_cnt = 0;
   int                max_page = 0;
   int                viol = 0;
   time               ras_fall = 0;
   time               ras_rise = 0;
   time               cas_fall = 0;
   time               seen [ROWS] = '{default: 0};
   always @(negedge row_strobe_n)
   begin
      if ($time - ras_rise < T_RP_NS) viol++;
      ras_fall = $time;
      page_cnt = 0;
      if (column_strobe_n === 1'b0)
      begin
         if ($time - cas_fall < T_CSR_NS) viol++;
         seen[refr_cnt] = $time;
         refr_cnt++;
         cbr_count++;
      end
      else
      begin
         row_q = mux_address_lines;
         row_open = 1'b1;
         seen[row_q] = $time;
      end
   end
   always @(posedge row_strobe_n)
   begin
      if (ras_fall > 0 && $time - ras_fall < T_RAS_NS) viol++;
      if (ras_fall > 0 && $time - ras_fall > T_RAS_MAX_NS) viol++;
      ras_rise = $time;
      row_open = 1'b0;
   end
   always @(negedge column_strobe_n)
   begin
      cas_fall = $time;
      acc_ok = 1'b0;
      if (row_open && row_strobe_n === 1'b0)
      begin
         col_q = mux_address_lines;
         page_cnt++;
         if (page_cnt > max_page) max_page = page_cnt;
         rd_act = write_select_n;
         if (!write_select_n) cells[{row_q, col_q}] = dq;
         else acc_ok <= #(acc_ns) 1'b1;
      end
   end
   always @(posedge column_strobe_n) rd_act = 1'b0;
   always @(negedge write_select_n)
      if (rd_act && column_strobe_n === 1'b0) cells[{row_q, col_q}] = dq;
   assign dq_oe = rd_act & acc_ok & ~column_strobe_n & ~output_gate_n;
   assign dq_q = cells[{row_q, col_q}];
endmodule

// File: tb_top.sv
// Self-checking bench for the page-mode dynamic memory host controller
`timescale 1ns/1ps
`define CHK(a, b) \
   begin total_checks++; if ((a) !== (b)) begin failures++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
   import dhc_pkg::*;
   localparam int REF_CYC = 12800;
   typedef struct {dhc_op_t op; logic [17:0] a; logic [3:0] w; logic [3:0] e;} dhc_row_t;
   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        req_valid = 1'b0;
   dhc_op_t     req_op = DHC_OP_READ;
   logic [17:0] req_addr = '0;
   logic [3:0]  req_wdata = '0;
   logic        req_ready, rsp_valid, row_strobe_n, column_strobe_n;
   logic        write_select_n, output_gate_n, data_pins_oe, mem_oe;
   logic [8:0]  mux_address_lines;
   logic [3:0]  rsp_rdata, data_pins_o, mem_q, pins;
   logic [3:0]  last_pins = '0;
   int          failures = 0;
   int          total_checks = 0;
   dhc_row_t rows [10] = '{
      '{DHC_OP_WRITE, 18'h00001, 4'h5, 4'h0}, '{DHC_OP_WRITE, 18'h00200, 4'ha, 4'h0},
      '{DHC_OP_WRITE, 18'h3ffff, 4'hc, 4'h0}, '{DHC_OP_WRITE, 18'h3fe00, 4'h3, 4'h0},
      '{DHC_OP_READ, 18'h00001, 4'h0, 4'h5}, '{DHC_OP_READ, 18'h00200, 4'h0, 4'ha},
      '{DHC_OP_READ, 18'h3ffff, 4'h0, 4'hc}, '{DHC_OP_READ, 18'h3fe00, 4'h0, 4'h3},
      '{DHC_OP_RMW, 18'h00001, 4'h9, 4'h5}, '{DHC_OP_READ, 18'h00001, 4'h0, 4'h9}};
   dhc_ctrl #(.REF_PERIOD_CYC(REF_CYC), .RAS_MAX_CYC(200)) dhc_ctrl_i (
      .mclk, .sys_rst, .req_valid, .req_ready, .req_op, .req_addr, .req_wdata, .rsp_valid,
      .rsp_rdata, .row_strobe_n, .column_strobe_n, .write_select_n, .output_gate_n,
      .mux_address_lines, .data_pins_o, .data_pins_oe, .data_pins_i(pins));
   dhc_dram_model dhc_dram_model_i (
      .row_strobe_n, .column_strobe_n, .write_select_n, .output_gate_n,
      .mux_address_lines, .dq(pins), .dq_q(mem_q), .dq_oe(mem_oe));
   always #(CLK_NS / 2) mclk = ~mclk;
   // Undriven pins wander rather than keep the last value
   always @*
      pins = data_pins_oe ? data_pins_o : (mem_oe ? mem_q : ~last_pins);
   always @(posedge mclk)
   begin
      if (!sys_rst)
      begin
         last_pins <= pins;
         `CHK(data_pins_oe & mem_oe, 1'b0)
      end
   end
   task automatic summarize;
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic req(input dhc_op_t op, input logic [17:0] a, input logic [3:0] w, output logic [3:0] r);
      int n;
      n = 0;
      req_op <= op;
      req_addr <= a;
      req_wdata <= w;
      req_valid <= 1'b1;
      do @(posedge mclk); while (req_ready !== 1'b1 && ++n < 100);
      req_valid <= 1'b0;
      do @(posedge mclk); while (rsp_valid !== 1'b1 && ++n < 200);
      `CHK(n < 200, 1'b1)
      r = rsp_rdata;
   endtask
   task automatic run_table(input int acc);
      logic [3:0] got;
      logic [3:0] exp;
      dhc_dram_model_i.acc_ns = acc;
      foreach (rows[i])
      begin
         req(rows[i].op, rows[i].a, rows[i].w, got);
         exp = (rows[i].op == DHC_OP_READ) ? rows[i].e : rows[i].w;
         if (rows[i].op != DHC_OP_WRITE)
            `CHK(got, rows[i].e)
         `CHK(dhc_dram_model_i.cells[rows[i].a], exp)
      end
      $display("table test with access %0d ns done", acc);
   endtask
   initial
   begin
      repeat (10) @(posedge mclk);
      `CHK(row_strobe_n, 1'b1)
      `CHK(column_strobe_n, 1'b1)
      `CHK(data_pins_oe, 1'b0)
      `CHK(rsp_valid, 1'b0)
      sys_rst <= 1'b0;
      $display("reset test done");
      run_table(30);
      run_table(70);
      `CHK(dhc_dram_model_i.max_page > 1, 1'b1)
      $display("page test done");
      repeat (REF_CYC + 50) @(posedge mclk);
      for (int r = 0; r < ROWS; r++)
         `CHK($time - dhc_dram_model_i.seen[r] <= REF_CYC * CLK_NS, 1'b1)
      `CHK(dhc_dram_model_i.cbr_count >= ROWS, 1'b1)
      `CHK(dhc_dram_model_i.viol, 0)
      $display("refresh and timing test done");
      summarize();
   end
   initial
   begin
      repeat (40000) @(posedge mclk);
      failures++;
      $display("watchdog expired");
      summarize();
   end
endmodule
